/* sim/uart_line_and_modem_status_test.sv */
// self-checking bench for the line and modem status block
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module uart_line_and_modem_status_test import uls_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4; // small store so it fills quickly
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic rx_done_in = 1'b0;
  logic [7:0] rx_byte_in = 8'h00;
  logic rx_parity_err_in = 1'b0;
  logic [3:0] want_n = 4'hf; // requested pins {cd, ri, dsr, cts}
  logic [3:0] pins_n; // pins from the modem model
  logic [3:0] mc_pins_n; // {dtr, rts, out1, out2} outputs
  logic [7:0] extra_feature_select_out;
  logic msr_irq_out;
  logic irq_out;
  int failures = 0;
  int cmp_count = 0;
  // free-running clock, 5 ns period
  always #2.5 clk_in = ~clk_in;
  uls_modem_model uls_modem_model_i (.clk_in(clk_in), .level_n_in(want_n), .pins_n_out(pins_n));
  uls_status_top #(.FIFO_DEPTH(DEPTH)) uls_status_top_i (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .rx_done_in(rx_done_in), .rx_byte_in(rx_byte_in), .rx_parity_err_in(rx_parity_err_in),
    .cts_n_in(pins_n[0]), .dsr_n_in(pins_n[1]), .ri_n_in(pins_n[2]),
    .carrier_detect_n_in(pins_n[3]), .dtr_n_out(mc_pins_n[3]), .rts_n_out(mc_pins_n[2]),
    .user_output_first_n_out(mc_pins_n[1]), .user_output_second_n_out(mc_pins_n[0]),
    .extra_feature_select_out(extra_feature_select_out), .msr_irq_out(msr_irq_out),
    .irq_out(irq_out));
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a hang
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    pwdata_in <= ~wd;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask : wr
  // read and compare one register
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    `CHK(d, exp)
  endtask : rd_chk
  // one receiver hand-off pulse; data lines scrambled outside it
  task automatic send_char(input logic [7:0] b, input logic pe);
    @(posedge clk_in);
    rx_done_in <= 1'b1;
    rx_byte_in <= b;
    rx_parity_err_in <= pe;
    @(posedge clk_in);
    rx_done_in <= 1'b0;
    rx_byte_in <= ~b;
    rx_parity_err_in <= ~pe;
  endtask : send_char
  // move the modem pins and let the synchroniser settle
  task automatic pins(input logic [3:0] v);
    @(posedge clk_in);
    want_n <= v;
    repeat (8) @(posedge clk_in);
  endtask : pins
  task automatic t_modem();
    pins(4'h0);
    `CHK(msr_irq_out, 1'b1)
    rd_chk(ULS_OFF_MODEM_STATUS, 32'hfb);
    rd_chk(ULS_OFF_MODEM_STATUS, 32'hf0);
    repeat (2) @(posedge clk_in);
    `CHK(msr_irq_out, 1'b0)
    pins(4'h4);
    rd_chk(ULS_OFF_MODEM_STATUS, 32'hb4);
    pins(4'h0);
    rd_chk(ULS_OFF_MODEM_STATUS, 32'hf0);
    pins(4'hf);
    // ring pin rises with the others here, so its change bit sets too
    rd_chk(ULS_OFF_MODEM_STATUS, 32'h0f);
  endtask : t_modem
  task automatic t_loop();
    wr(ULS_OFF_MODEM_CONTROL, 32'h15);
    repeat (4) @(posedge clk_in);
    `CHK(mc_pins_n, 4'hf)
    rd_chk(ULS_OFF_MODEM_STATUS, 32'h62);
    pins(4'h0);
    rd_chk(ULS_OFF_MODEM_STATUS, 32'h60);
    wr(ULS_OFF_MODEM_CONTROL, 32'h1a);
    rd_chk(ULS_OFF_MODEM_STATUS, 32'h9f);
    wr(ULS_OFF_MODEM_CONTROL, 32'h03);
    repeat (4) @(posedge clk_in);
    `CHK(mc_pins_n, 4'h3)
    rd_chk(ULS_OFF_MODEM_STATUS, 32'hf2);
    pins(4'hf);
    rd_chk(ULS_OFF_MODEM_STATUS, 32'h0f);
    wr(ULS_OFF_MODEM_CONTROL, 32'h00);
  endtask : t_loop
  task automatic t_feature();
    wr(ULS_OFF_MODEM_STATUS, 32'ha5);
    rd_chk(ULS_OFF_MODEM_STATUS, 32'h00);
    `CHK(extra_feature_select_out, 8'ha5)
  endtask : t_feature
  // fill the store past full, then drain it in order
  task automatic t_rx();
    rd_chk(ULS_OFF_LINE_STATUS, 32'h00);
    wr(ULS_OFF_FIFO_CONTROL, 32'h1);
    for (int i = 0; i <= DEPTH; i++) send_char(8'h30 + 8'(i), i == 0);
    rd_chk(ULS_OFF_LINE_STATUS, 32'h07);
    rd_chk(ULS_OFF_LINE_STATUS, 32'h05);
    rd_chk(ULS_OFF_RX_DATA, 32'h30);
    rd_chk(ULS_OFF_LINE_STATUS, 32'h01);
    for (int i = 1; i < DEPTH; i++) rd_chk(ULS_OFF_RX_DATA, 32'h30 + i);
    rd_chk(ULS_OFF_LINE_STATUS, 32'h00);
  endtask : t_rx
  // interrupt raise, clear, mask; then an unmapped address
  task automatic t_irq();
    logic [31:0] d;
    logic e;
    wr(ULS_OFF_IRQ_STATUS, 32'h7);
    wr(ULS_OFF_IRQ_MASK, 32'h4);
    send_char(8'h5a, 1'b0);
    repeat (2) @(posedge clk_in);
    `CHK(irq_out, 1'b1)
    wr(ULS_OFF_IRQ_STATUS, 32'h4);
    wr(ULS_OFF_IRQ_MASK, 32'h0);
    send_char(8'h5b, 1'b0);
    repeat (2) @(posedge clk_in);
    `CHK(irq_out, 1'b0)
    rd_chk(ULS_OFF_IRQ_STATUS, 32'h4);
    rd_chk(ULS_OFF_RX_DATA, 32'h5a);
    rd_chk(ULS_OFF_RX_DATA, 32'h5b);
    apb(1'b0, 8'h1c, 32'h0, d, e);
    `CHK({e, d}, 33'h100000000)
  endtask : t_irq
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_modem();
    t_loop();
    t_feature();
    t_rx();
    t_irq();
    give_verdict();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule : uart_line_and_modem_status_test

/* sim/uls_modem_model.sv */
// modem side model: drives the four active-low control pins of the block
module uls_modem_model (
  input wire logic clk_in,
  input wire logic [3:0] level_n_in, // wanted pin levels, {cd, ri, dsr, cts}
  output logic [3:0] pins_n_out // pins as the block sees them
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle high, as an unplugged modem leaves them
  initial pins_n_out = 4'hf;
  // levels move one edge after the request, like a slow peripheral
  always @(posedge clk_in) begin
    pins_n_out <= level_n_in;
  end
endmodule : uls_modem_model

/* sim/uls_status_checker.sv */
// concurrent checks on the ports of the status block
module uls_status_checker import uls_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic carrier_detect_n_in,
  input wire logic [7:0] extra_feature_select_out,
  input wire logic msr_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic done_w; // transfer completes at this edge
  logic mc_wr_w; // modem_control write completes
  logic [3:0] pins_w; // pins as {cd, ri, dsr, cts}
  logic [3:0] pins_q; // pins one edge ago
  logic [3:0] stab_q; // edges since pins moved or modem_control was written, saturating
  logic [4:0] mc_q; // shadow of modem_control
  logic [7:0] wd_q; // write data one edge ago
  assign done_w = psel_in && penable_in && pready_out;
  assign mc_wr_w = done_w && pwrite_in && paddr_in == ULS_OFF_MODEM_CONTROL;
  assign pins_w = {carrier_detect_n_in, ri_n_in, dsr_n_in, cts_n_in};
  // shadow modem_control so loopback values can be predicted
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mc_q <= 5'h00;
    end else if (mc_wr_w) begin
      mc_q <= pwdata_in[4:0];
    end
  end
  // quiet-time counter: a fresh change may still be in the synchroniser
  always_ff @(posedge clk_in) begin
    pins_q <= pins_w;
    wd_q <= pwdata_in[7:0];
    if (sys_rst_in || pins_w != pins_q || mc_wr_w) begin
      stab_q <= 4'h0;
    end else if (stab_q != 4'hf) begin
      stab_q <= stab_q + 4'h1;
    end
  end
  sequence s_rd_ms;
    done_w && !pwrite_in && paddr_in == ULS_OFF_MODEM_STATUS;
  endsequence
  sequence s_wr_ms;
    done_w && pwrite_in && paddr_in == ULS_OFF_MODEM_STATUS;
  endsequence
  property p_norm_levels;
    s_rd_ms ##0 (!mc_q[4] && stab_q > 4'h5) |-> prdata_out[7:4] == ~pins_w;
  endproperty
  a_norm_levels: assert property (p_norm_levels) else $error("modem levels wrong");
  property p_loop_levels;
    s_rd_ms ##0 mc_q[4] |-> prdata_out[7:4] == {mc_q[3], mc_q[2], mc_q[0], mc_q[1]};
  endproperty
  a_loop_levels: assert property (p_loop_levels) else $error("loopback levels wrong");
  property p_rd_clears;
    s_rd_ms ##0 (stab_q > 4'h5) |-> ##2 !msr_irq_out;
  endproperty
  a_rd_clears: assert property (p_rd_clears) else $error("read left change flags");
  property p_edge_any;
    !mc_q[4] && (pins_w[3] != pins_q[3] || pins_w[1:0] != pins_q[1:0]) |-> ##[3:5] msr_irq_out;
  endproperty
  a_edge_any: assert property (p_edge_any) else $error("pin change not flagged");
  property p_ring_rise;
    !mc_q[4] && ri_n_in && !pins_q[2] |-> ##[3:5] msr_irq_out;
  endproperty
  a_ring_rise: assert property (p_ring_rise) else $error("ring rise not flagged");
  property p_ring_fall;
    !mc_q[4] && !ri_n_in && pins_q[2] && stab_q > 4'h5 && !msr_irq_out |-> ##4 !msr_irq_out;
  endproperty
  a_ring_fall: assert property (p_ring_fall) else $error("ring fall flagged");
  property p_fs_write;
    s_wr_ms |=> extra_feature_select_out == wd_q;
  endproperty
  a_fs_write: assert property (p_fs_write) else $error("feature select not stored");
  property p_fs_quiet;
    s_wr_ms ##0 (stab_q > 4'h5 && !msr_irq_out) |-> ##2 !msr_irq_out;
  endproperty
  a_fs_quiet: assert property (p_fs_quiet) else $error("write touched modem status");
  property p_rd_ok;
    s_rd_ms |-> !pslverr_out;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("modem status read refused");
endmodule : uls_status_checker
bind uls_status_top uls_status_checker uls_status_checker_i (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .cts_n_in(cts_n_in),
  .dsr_n_in(dsr_n_in), .ri_n_in(ri_n_in), .carrier_detect_n_in(carrier_detect_n_in),
  .extra_feature_select_out(extra_feature_select_out), .msr_irq_out(msr_irq_out));

/* src/uls_pkg.sv */
// package for the uart line and modem status block: register map, fields, types
// Behaviour
// (R1) parity flag follows character at fifo top
// (R2) overrun flag sets when full fifo meets character
// (R3) overrun overwrites shift register, fifo stays intact
// (R4) data ready high while any character stored
// (R5) modem status read-only, shares feature select address
// (R6) writes there go to feature select register
// (R7) reading modem status clears change bits 3:0
// (R8) bit 7 is carrier detect, loopback user_output_second
// (R9) bit 6 is ring indicator, loopback user_output_first
// (R10) bit 5 is data set ready, loopback terminal ready
// (R11) bit 4 is clear to send, loopback request-to-send
// (R12) bits 3,1,0 latch on any input change
// (R13) bit 2 latches only on ring trailing edge
// (R14) modem interrupt while any change bit set
// (R15) synchronise modem inputs before edge detection
package uls_pkg;

  // apb byte addresses, one aligned word each
  localparam logic [7:0] ULS_OFF_RX_DATA = 8'h00; // receive holding / fifo top, pops on read
  localparam logic [7:0] ULS_OFF_LINE_STATUS = 8'h04; // line_status, read-only
  localparam logic [7:0] ULS_OFF_MODEM_STATUS = 8'h08; // modem_status read, feature select write
  localparam logic [7:0] ULS_OFF_MODEM_CONTROL = 8'h0c; // modem_control, read/write
  localparam logic [7:0] ULS_OFF_FIFO_CONTROL = 8'h10; // fifo mode enable
  localparam logic [7:0] ULS_OFF_IRQ_STATUS = 8'h14; // sticky events, write one to clear
  localparam logic [7:0] ULS_OFF_IRQ_MASK = 8'h18; // event mask, same layout

  // line_status bit positions
  localparam int ULS_LS_DATA_READY = 0;
  localparam int ULS_LS_OVERRUN = 1;
  localparam int ULS_LS_PARITY = 2;

  // modem_control bit positions
  localparam int ULS_MC_DTR = 0;
  localparam int ULS_MC_RTS = 1;
  localparam int ULS_MC_OUT1 = 2;
  localparam int ULS_MC_OUT2 = 3;
  localparam int ULS_MC_LOOP = 4;

  // fifo_control bit position
  localparam int ULS_FC_ENABLE = 0;

  // interrupt status / mask bit positions
  localparam int ULS_IRQ_MODEM = 0;
  localparam int ULS_IRQ_OVERRUN = 1;
  localparam int ULS_IRQ_DATA = 2;

  // reset values
  localparam logic [7:0] ULS_RST_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] ULS_RST_FEATURE_SELECT = 8'h00;
  localparam logic ULS_RST_FIFO_ENABLE = 1'b0;
  localparam logic [2:0] ULS_RST_IRQ_MASK = 3'h0;
  localparam logic [3:0] ULS_RST_MODEM_PINS = 4'hf; // idle level of active-low pins

  // timing counts
  localparam int ULS_SYNC_STAGES = 2;

  // modem status as seen by software, complement of the active-low pins, or the modem control bits in loopback
  typedef struct packed {
    logic cd;  // carrier detect, bit 7
    logic ri;  // ring indicator, bit 6
    logic dsr; // data set ready, bit 5
    logic cts; // clear to send, bit 4
  } uls_modem_t;

  // one received character with its parity verdict
  typedef struct packed {
    logic parity_err;
    logic [7:0] data;
  } uls_rx_char_t;

  // apb slave phases
  typedef enum logic [1:0] {
    ULS_APB_IDLE = 2'b00,
    ULS_APB_WAIT = 2'b01,
    ULS_APB_DONE = 2'b10
  } uls_apb_t;

endpackage : uls_pkg

/* src/uls_status_top.sv */
// uart line status and modem status block with apb register access
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
module uls_status_top import uls_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // receiver shift register hand-off, same clock
  input wire logic rx_done_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_parity_err_in,
  // modem control pins, active low, asynchronous
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic carrier_detect_n_in,
  // modem control outputs, active low
  output logic dtr_n_out,
  output logic rts_n_out,
  output logic user_output_first_n_out,
  output logic user_output_second_n_out,
  // stored feature select value for the register bank mux
  output logic [7:0] extra_feature_select_out,
  // interrupts
  output logic msr_irq_out,
  output logic irq_out
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;

  // apb handshake state
  uls_apb_t apb_q;
  logic rd_done; // read completes this edge
  logic wr_done; // write completes this edge

  // software registers
  logic [7:0] modem_control_q;
  logic fifo_enable_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;

  // receive store
  uls_rx_char_t rx_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  uls_rx_char_t rx_shift_q; // last character off the line
  logic fifo_full;
  logic push;
  logic pop;
  logic flush;
  logic overrun_q;
  logic overrun_ev;
  logic [7:0] line_status;

  // modem status
  logic [3:0] pins_sync; // {cd, ri, dsr, cts} active low
  uls_modem_t modem_now;
  uls_modem_t modem_prev_q;
  logic [3:0] delta_q; // {dcd, teri, ddsr, dcts}
  logic [3:0] delta_set;
  logic [7:0] modem_status;

  // word chosen by the read mux; prdata_out registers it, and the read-clear masks with prdata_out
  logic [31:0] rd_word;

  // decode helper, true when the completing access hits an offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // known offsets for the slave error answer
  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, ULS_OFF_RX_DATA) || hit(addr, ULS_OFF_LINE_STATUS) ||
             hit(addr, ULS_OFF_MODEM_STATUS) || hit(addr, ULS_OFF_MODEM_CONTROL) ||
             hit(addr, ULS_OFF_FIFO_CONTROL) || hit(addr, ULS_OFF_IRQ_STATUS) ||
             hit(addr, ULS_OFF_IRQ_MASK);
  endfunction : mapped

  // ------------------------------------------------------------------
  // apb slave: one wait state so prdata and pready come from flops
  // ------------------------------------------------------------------

  // phase tracking: first access cycle loads data, wait state completes, done state lets penable drop
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      apb_q <= ULS_APB_IDLE;
    end else begin
      case (apb_q)
        ULS_APB_IDLE: begin
          if (psel_in && penable_in) begin
            apb_q <= ULS_APB_WAIT;
          end
        end
        ULS_APB_WAIT: begin
          apb_q <= ULS_APB_DONE; // pready is high during this state
        end
        ULS_APB_DONE: begin
          apb_q <= ULS_APB_IDLE; // master drops penable after completion
        end
        default: begin
          apb_q <= ULS_APB_IDLE;
        end
      endcase
    end
  end

  // the transfer is taken at the edge where pready is seen high
  assign rd_done = (apb_q == ULS_APB_WAIT) && psel_in && penable_in && !pwrite_in;
  assign wr_done = (apb_q == ULS_APB_WAIT) && psel_in && penable_in && pwrite_in;

  // read mux, zero for unmapped or write-only addresses
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(paddr_in, ULS_OFF_RX_DATA)) begin
      rd_word[7:0] = (count_q != '0) ? rx_mem[rd_ptr_q].data : 8'h00;
    end else if (hit(paddr_in, ULS_OFF_LINE_STATUS)) begin
      rd_word[7:0] = line_status;
    end else if (hit(paddr_in, ULS_OFF_MODEM_STATUS)) begin
      rd_word[7:0] = modem_status; // (R5)
    end else if (hit(paddr_in, ULS_OFF_MODEM_CONTROL)) begin
      rd_word[7:0] = modem_control_q;
    end else if (hit(paddr_in, ULS_OFF_FIFO_CONTROL)) begin
      rd_word[ULS_FC_ENABLE] = fifo_enable_q;
    end else if (hit(paddr_in, ULS_OFF_IRQ_STATUS)) begin
      rd_word[2:0] = irq_status_q;
    end else if (hit(paddr_in, ULS_OFF_IRQ_MASK)) begin
      rd_word[2:0] = irq_mask_q;
    end
  end

  // response registers, loaded in the first access cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= (apb_q == ULS_APB_IDLE) && psel_in && penable_in;
      if ((apb_q == ULS_APB_IDLE) && psel_in && penable_in) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd_word;
        pslverr_out <= !mapped(paddr_in);
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // writable control registers
  // ------------------------------------------------------------------

  // modem control, loopback lives in bit 4
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      modem_control_q <= ULS_RST_MODEM_CONTROL;
    end else if (wr_done && hit(paddr_in, ULS_OFF_MODEM_CONTROL)) begin
      modem_control_q <= pwdata_in[7:0];
    end
  end

  // shared address: writes land here, modem status is never written
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      extra_feature_select_out <= ULS_RST_FEATURE_SELECT;
    end else if (wr_done && hit(paddr_in, ULS_OFF_MODEM_STATUS)) begin
      extra_feature_select_out <= pwdata_in[7:0]; // (R6)
    end
  end

  // fifo mode switch; a mode change empties the store
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fifo_enable_q <= ULS_RST_FIFO_ENABLE;
    end else if (wr_done && hit(paddr_in, ULS_OFF_FIFO_CONTROL)) begin
      fifo_enable_q <= pwdata_in[ULS_FC_ENABLE];
    end
  end

  assign flush = wr_done && hit(paddr_in, ULS_OFF_FIFO_CONTROL) &&
                 (pwdata_in[ULS_FC_ENABLE] != fifo_enable_q);

  // interrupt mask
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_mask_q <= ULS_RST_IRQ_MASK;
    end else if (wr_done && hit(paddr_in, ULS_OFF_IRQ_MASK)) begin
      irq_mask_q <= pwdata_in[2:0];
    end
  end

  // ------------------------------------------------------------------
  // receive store and line status
  // ------------------------------------------------------------------

  // without fifo mode the holding register is a one-deep store
  assign fifo_full = fifo_enable_q ? (count_q == CW'(FIFO_DEPTH)) : (count_q != '0);
  assign push = rx_done_in && !fifo_full && !flush;
  assign overrun_ev = rx_done_in && fifo_full && !flush; // (R2)
  assign pop = rd_done && hit(paddr_in, ULS_OFF_RX_DATA) && (count_q != '0);

  // shift register copy, overwritten on every arrival even when full
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_shift_q <= '0;
    end else if (rx_done_in) begin
      rx_shift_q <= '{parity_err: rx_parity_err_in, data: rx_byte_in}; // (R3)
    end
  end

  // storage array, written only when there is room
  always_ff @(posedge clk_in) begin
    if (push) begin
      rx_mem[wr_ptr_q] <= '{parity_err: rx_parity_err_in, data: rx_byte_in}; // (R3)
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      case ({push, pop})
        2'b10: count_q <= count_q + 1'b1;
        2'b01: count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  // overrun stays until line status is read; a new overrun beats the clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      overrun_q <= 1'b0;
    end else if (overrun_ev) begin
      overrun_q <= 1'b1; // (R2)
    end else if (rd_done && hit(paddr_in, ULS_OFF_LINE_STATUS) &&
                 prdata_out[ULS_LS_OVERRUN]) begin
      overrun_q <= 1'b0;
    end
  end

  // line status bits 2:0; upper bits belong elsewhere and read zero
  always_comb begin
    line_status = 8'h00;
    line_status[ULS_LS_DATA_READY] = (count_q != '0); // (R4)
    line_status[ULS_LS_OVERRUN] = overrun_q; // (R2)
    // parity verdict of the character at the top of the store
    line_status[ULS_LS_PARITY] = (count_q != '0) && rx_mem[rd_ptr_q].parity_err; // (R1)
  end

  // ------------------------------------------------------------------
  // modem status
  // ------------------------------------------------------------------

  // pin levels cross into the clock domain before any edge detection
  uls_sync2 #(
    .WIDTH(4),
    .RESET_VAL(ULS_RST_MODEM_PINS)
  ) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({carrier_detect_n_in, ri_n_in, dsr_n_in, cts_n_in}), // (R15)
    .sync_out(pins_sync)
  );

  // live modem view: pin complements, or modem control bits in loopback
  always_comb begin
    if (modem_control_q[ULS_MC_LOOP]) begin
      modem_now.cd = modem_control_q[ULS_MC_OUT2]; // (R8)
      modem_now.ri = modem_control_q[ULS_MC_OUT1]; // (R9)
      modem_now.dsr = modem_control_q[ULS_MC_DTR]; // (R10)
      modem_now.cts = modem_control_q[ULS_MC_RTS]; // (R11)
    end else begin
      modem_now.cd = !pins_sync[3]; // (R8)
      modem_now.ri = !pins_sync[2]; // (R9)
      modem_now.dsr = !pins_sync[1]; // (R10)
      modem_now.cts = !pins_sync[0]; // (R11)
    end
  end

  // previous view for edge detection
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      modem_prev_q <= '0;
    end else begin
      modem_prev_q <= modem_now;
    end
  end

  // change events; ring counts only the pin rising back to high
  always_comb begin
    delta_set[3] = modem_now.cd != modem_prev_q.cd; // (R12)
    delta_set[2] = modem_prev_q.ri && !modem_now.ri; // (R13)
    delta_set[1] = modem_now.dsr != modem_prev_q.dsr; // (R12)
    delta_set[0] = modem_now.cts != modem_prev_q.cts; // (R12)
  end

  // change flags; only bits software actually saw are cleared, new events win
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      delta_q <= 4'h0;
    end else if (rd_done && hit(paddr_in, ULS_OFF_MODEM_STATUS)) begin
      delta_q <= (delta_q & ~prdata_out[3:0]) | delta_set; // (R7)
    end else begin
      delta_q <= delta_q | delta_set; // (R12)
    end
  end

  assign modem_status = {modem_now, delta_q};

  // ------------------------------------------------------------------
  // interrupts and pin outputs
  // ------------------------------------------------------------------

  // modem interrupt request, level, one cycle behind the flags
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      msr_irq_out <= 1'b0;
    end else begin
      msr_irq_out <= |delta_q; // (R14)
    end
  end

  // sticky events: modem flag rise, overrun, data arrival; set beats clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_status_q <= 3'h0;
    end else begin
      if (wr_done && hit(paddr_in, ULS_OFF_IRQ_STATUS)) begin
        irq_status_q <= (irq_status_q & ~pwdata_in[2:0]) |
                        {push, overrun_ev, |(delta_set & ~delta_q)};
      end else begin
        irq_status_q <= irq_status_q | {push, overrun_ev, |(delta_set & ~delta_q)};
      end
    end
  end

  // combined interrupt, high while an unmasked status bit is set
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_q & irq_mask_q);
    end
  end

  // modem outputs follow control bits, held inactive in loopback
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dtr_n_out <= 1'b1;
      rts_n_out <= 1'b1;
      user_output_first_n_out <= 1'b1;
      user_output_second_n_out <= 1'b1;
    end else begin
      dtr_n_out <= !modem_control_q[ULS_MC_DTR] || modem_control_q[ULS_MC_LOOP];
      rts_n_out <= !modem_control_q[ULS_MC_RTS] || modem_control_q[ULS_MC_LOOP];
      user_output_first_n_out <= !modem_control_q[ULS_MC_OUT1] || modem_control_q[ULS_MC_LOOP];
      user_output_second_n_out <= !modem_control_q[ULS_MC_OUT2] || modem_control_q[ULS_MC_LOOP];
    end
  end

endmodule : uls_status_top

/* src/uls_sync2.sv */
// two flip-flop synchroniser for asynchronous pin levels
module uls_sync2 import uls_pkg::*; #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_q;

  // reset to the idle pin level so no change is seen on release
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : uls_sync2
